// ===== include/embedded_block_ram_regs.svh
`ifndef EMBEDDED_BLOCK_RAM_REGS_SVH
`define EMBEDDED_BLOCK_RAM_REGS_SVH

// Register byte offsets
`define EBR_CTRL_OFS        8'h00
`define EBR_PORT_A_CFG_OFS  8'h04
`define EBR_PORT_B_CFG_OFS  8'h08
`define EBR_LOAD_ADDR_OFS   8'h0c
`define EBR_LOAD_DATA_OFS   8'h10
`define EBR_STATUS_OFS      8'h14

// Control fields
`define EBR_CTRL_MODE_LSB   0
`define EBR_CTRL_MODE_W     3
`define EBR_CTRL_RUN_BIT    3
`define EBR_CTRL_RST        32'h0000_0000

// Port configuration fields
`define EBR_CFG_SHAPE_LSB   0
`define EBR_CFG_SHAPE_W     4
`define EBR_CFG_WMODE_LSB   4
`define EBR_CFG_WMODE_W     2
`define EBR_CFG_PIPE_BIT    6
`define EBR_CFG_BSEL_LSB    7
`define EBR_CFG_BSEL_W      3
`define EBR_CFG_RST         32'h0000_0003

// Array shape
`define EBR_ARRAY_BITS      18432
`define EBR_BYTES           2048
`define EBR_BYTE_IDX_W      11
`define EBR_ADDR_W          14
`define EBR_DATA_W          36

// Bus answers
`define EBR_RESP_OKAY       2'h0
`define EBR_RESP_SLVERR     2'h2

`endif

// ===== include/embedded_block_ram_pkg.sv
package embedded_block_ram_pkg;

    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h0,
        MODE_DUAL   = 3'h1,
        MODE_SEMI   = 3'h2,
        MODE_ROM    = 3'h3,
        MODE_FIFO   = 3'h4
    } ram_mode_e;

    typedef enum logic [3:0] {
        SHAPE_X1  = 4'h0,
        SHAPE_X2  = 4'h1,
        SHAPE_X4  = 4'h2,
        SHAPE_X8  = 4'h3,
        SHAPE_X16 = 4'h4,
        SHAPE_X32 = 4'h5,
        SHAPE_X9  = 4'h6,
        SHAPE_X18 = 4'h7,
        SHAPE_X36 = 4'h8
    } shape_e;

    typedef enum logic [1:0] {
        WM_NORMAL     = 2'h0,
        WM_THROUGH    = 2'h1,
        WM_READ_FIRST = 2'h2
    } write_mode_e;

endpackage

// ===== verilog/embedded_block_ram.sv
`timescale 1ns/1ns
`include "embedded_block_ram_regs.svh"

module embedded_block_ram
    import embedded_block_ram_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AXI4-Lite register slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Shared block select
    input  wire logic [2:0]  block_select,
    // Port A
    input  wire logic        port_a_clk,
    input  wire logic        port_a_clk_en,
    input  wire logic        port_a_reg_clear,
    input  wire logic        port_a_write_sel,
    input  wire logic        port_a_out_reg_en,
    input  wire logic [13:0] port_a_addr,
    input  wire logic [35:0] port_a_write_data,
    input  wire logic [3:0]  port_a_byte_en,
    output logic [35:0]      port_a_read_data,
    // Port B
    input  wire logic        port_b_clk,
    input  wire logic        port_b_clk_en,
    input  wire logic        port_b_reg_clear,
    input  wire logic        port_b_write_sel,
    input  wire logic        port_b_out_reg_en,
    input  wire logic [13:0] port_b_addr,
    input  wire logic [35:0] port_b_write_data,
    input  wire logic [3:0]  port_b_byte_en,
    output logic [35:0]      port_b_read_data
);

    localparam int BYTES = `EBR_BYTES;

    function automatic logic nine_bit(input shape_e s);
        return s == SHAPE_X9 || s == SHAPE_X18 || s == SHAPE_X36;
    endfunction

    function automatic int nbytes(input shape_e s);
        case (s)
            SHAPE_X16, SHAPE_X18: return 2;
            SHAPE_X32, SHAPE_X36: return 4;
            default:              return 1;
        endcase
    endfunction

    // Byte index of the word and bit offset for sub-byte shapes
    function automatic logic [10:0] base_of(input shape_e s,
                                            input logic [13:0] a);
        case (s)
            SHAPE_X1:             return a[13:3];
            SHAPE_X2:             return a[12:2];
            SHAPE_X4:             return a[11:1];
            SHAPE_X16, SHAPE_X18: return {a[9:0], 1'b0};
            SHAPE_X32, SHAPE_X36: return {a[8:0], 2'b00};
            default:              return a[10:0];
        endcase
    endfunction

    function automatic logic [2:0] off_of(input shape_e s,
                                          input logic [13:0] a);
        case (s)
            SHAPE_X1: return a[2:0];
            SHAPE_X2: return {a[1:0], 1'b0};
            SHAPE_X4: return {a[0], 2'b00};
            default:  return 3'h0;
        endcase
    endfunction

    function automatic logic [7:0] sub_mask(input shape_e s);
        case (s)
            SHAPE_X1: return 8'h01;
            SHAPE_X2: return 8'h03;
            default:  return 8'h0f;
        endcase
    endfunction

    // Assemble a port word from four stored bytes
    function automatic logic [35:0] word_of(input shape_e s,
                                            input logic [2:0] off,
                                            input logic [35:0] b);
        logic [35:0] w;
        w = 36'h0;
        if (s == SHAPE_X1 || s == SHAPE_X2 || s == SHAPE_X4) begin
            w[7:0] = (b[7:0] >> off) & sub_mask(s);
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (i < nbytes(s)) begin
                    if (nine_bit(s)) w[9*i +: 9] = b[9*i +: 9];
                    else             w[8*i +: 8] = b[9*i +: 8];
                end
            end
        end
        return w;
    endfunction

    // Which port may do what in each mode
    function automatic logic may_write(input ram_mode_e m, input int p);
        case (m)
            MODE_DUAL: return 1'b1;
            MODE_ROM:  return 1'b0;
            default:   return p == 0;
        endcase
    endfunction

    function automatic logic may_read(input ram_mode_e m, input int p);
        case (m)
            MODE_SINGLE:           return p == 0;
            MODE_SEMI, MODE_FIFO:  return p == 1;
            default:               return 1'b1;
        endcase
    endfunction

    function automatic logic shape_ok(input ram_mode_e m, input shape_e s);
        if (s > SHAPE_X36) return 1'b0;
        if (m == MODE_DUAL && (s == SHAPE_X32 || s == SHAPE_X36))
            return 1'b0;
        return 1'b1;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] o,
                                               input logic [31:0] n,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) if (st[i]) r[8*i +: 8] = n[8*i +: 8];
        return r;
    endfunction

    // Bus and configuration state
    logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] cfg_q [2];
    logic [31:0] cfg_d [2];
    logic [10:0] ld_addr_q, ld_addr_d;
    logic        ld_we;
    // Memory and port state
    logic [8:0]  mem_q [BYTES];
    logic [8:0]  mem_d [BYTES];
    logic [1:0]  pclk_q, pclk_d;
    logic [35:0] arr_q [2];
    logic [35:0] arr_d [2];
    logic [35:0] dout_q [2];
    logic [35:0] dout_d [2];

    logic        run;
    ram_mode_e   mode;
    assign run  = ctrl_q[`EBR_CTRL_RUN_BIT];
    assign mode = ram_mode_e'(ctrl_q[`EBR_CTRL_MODE_LSB +: `EBR_CTRL_MODE_W]);

    always_comb begin
        logic do_wr;
        do_wr = awh_q & wh_q & ~bv_q;
        awh_d = awh_q; awa_d = awa_q; wh_d = wh_q; wd_d = wd_q; ws_d = ws_q;
        bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
        ctrl_d = ctrl_q; cfg_d = cfg_q; ld_addr_d = ld_addr_q; ld_we = 1'b0;
        if (s_axi_awvalid & ~awh_q) begin
            awh_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~wh_q) begin
            wh_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (bv_q & s_axi_bready) bv_d = 1'b0;
        if (do_wr) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = `EBR_RESP_OKAY;
            case (awa_q)
                `EBR_CTRL_OFS:       ctrl_d = strb_merge(ctrl_q, wd_q, ws_q);
                `EBR_PORT_A_CFG_OFS: cfg_d[0] = strb_merge(cfg_q[0], wd_q, ws_q);
                `EBR_PORT_B_CFG_OFS: cfg_d[1] = strb_merge(cfg_q[1], wd_q, ws_q);
                `EBR_LOAD_ADDR_OFS:  ld_addr_d = wd_q[10:0];
                `EBR_LOAD_DATA_OFS: begin
                    // Loading is refused once user access runs
                    if (~run) begin
                        ld_we     = 1'b1;
                        ld_addr_d = ld_addr_q + 11'h1;
                    end
                end
                `EBR_STATUS_OFS: ;
                default: br_d = `EBR_RESP_SLVERR;
            endcase
        end
        if (rv_q & s_axi_rready) rv_d = 1'b0;
        if (s_axi_arvalid & ~rv_q) begin
            rv_d = 1'b1;
            rr_d = `EBR_RESP_OKAY;
            case (s_axi_araddr)
                `EBR_CTRL_OFS:       rd_d = ctrl_q;
                `EBR_PORT_A_CFG_OFS: rd_d = cfg_q[0];
                `EBR_PORT_B_CFG_OFS: rd_d = cfg_q[1];
                `EBR_LOAD_ADDR_OFS:  rd_d = {21'h0, ld_addr_q};
                `EBR_LOAD_DATA_OFS:  rd_d = {23'h0, mem_q[ld_addr_q]};
                `EBR_STATUS_OFS:     rd_d = {31'h0, run};
                default: begin
                    rd_d = 32'h0;
                    rr_d = `EBR_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            awh_q <= 1'b0; wh_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
            awa_q <= 8'h0; wd_q <= 32'h0; ws_q <= 4'h0; rd_q <= 32'h0;
            br_q <= 2'h0; rr_q <= 2'h0; ld_addr_q <= 11'h0;
            ctrl_q <= `EBR_CTRL_RST;
            cfg_q  <= '{`EBR_CFG_RST, `EBR_CFG_RST};
        end else begin
            awh_q <= awh_d; wh_q <= wh_d; bv_q <= bv_d; rv_q <= rv_d;
            awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
            br_q <= br_d; rr_q <= rr_d; ld_addr_q <= ld_addr_d;
            ctrl_q <= ctrl_d;
            cfg_q  <= cfg_d;
        end
    end

    assign s_axi_awready = ~awh_q;
    assign s_axi_wready  = ~wh_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = ~rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;

    // Port inputs gathered by index so both ports share one description
    logic [1:0]  p_clk, p_ce, p_clr, p_wsel, p_oce;
    logic [13:0] p_addr [2];
    logic [35:0] p_wdat [2];
    logic [3:0]  p_be [2];
    assign p_clk  = {port_b_clk, port_a_clk};
    assign p_ce   = {port_b_clk_en, port_a_clk_en};
    assign p_clr  = {port_b_reg_clear, port_a_reg_clear};
    assign p_wsel = {port_b_write_sel, port_a_write_sel};
    assign p_oce  = {port_b_out_reg_en, port_a_out_reg_en};
    assign p_addr = '{port_a_addr, port_b_addr};
    assign p_wdat = '{port_a_write_data, port_b_write_data};
    assign p_be   = '{port_a_byte_en, port_b_byte_en};

    // Port edges are taken from sampled port clocks; port B acts after
    // port A, so a same-byte collision in dual mode keeps B's data.
    always_comb begin
        logic        edge_v, act, wr, rdo;
        shape_e      s;
        write_mode_e wm;
        logic [10:0] base, idx;
        logic [2:0]  off;
        logic [7:0]  m8;
        logic [35:0] ob, nb;
        mem_d = mem_q; arr_d = arr_q; dout_d = dout_q;
        edge_v = 1'b0; act = 1'b0; wr = 1'b0; rdo = 1'b0;
        s = SHAPE_X1; wm = WM_NORMAL; base = 11'h0; idx = 11'h0;
        off = 3'h0; m8 = 8'h0; ob = 36'h0; nb = 36'h0;
        pclk_d = p_clk;
        if (ld_we) mem_d[ld_addr_q] = wd_q[8:0];
        for (int p = 0; p < 2; p++) begin
            s  = shape_e'(cfg_q[p][`EBR_CFG_SHAPE_LSB +: `EBR_CFG_SHAPE_W]);
            wm = write_mode_e'(cfg_q[p][`EBR_CFG_WMODE_LSB +: `EBR_CFG_WMODE_W]);
            edge_v = p_clk[p] & ~pclk_q[p];
            act = edge_v & p_ce[p] & run
                & (block_select
                   == cfg_q[p][`EBR_CFG_BSEL_LSB +: `EBR_CFG_BSEL_W])
                & shape_ok(mode, s);
            wr  = act & p_wsel[p] & may_write(mode, p);
            rdo = act & ~p_wsel[p] & may_read(mode, p);
            base = base_of(s, p_addr[p]);
            off  = off_of(s, p_addr[p]);
            m8   = sub_mask(s) << off;
            for (int i = 0; i < 4; i++) begin
                idx = base + 11'(i);
                ob[9*i +: 9] = mem_d[idx];
                nb[9*i +: 9] = mem_d[idx];
                // Single-byte words ignore the byte enables
                if (i < nbytes(s) && (nbytes(s) == 1 || p_be[p][i])) begin
                    if (s == SHAPE_X1 || s == SHAPE_X2 || s == SHAPE_X4)
                        nb[9*i +: 8] = (ob[9*i +: 8] & ~m8)
                                     | ((p_wdat[p][7:0] << off) & m8);
                    else if (nine_bit(s))
                        nb[9*i +: 9] = p_wdat[p][9*i +: 9];
                    else
                        nb[9*i +: 8] = p_wdat[p][8*i +: 8];
                end
                if (wr) mem_d[idx] = nb[9*i +: 9];
            end
            if (rdo) arr_d[p] = word_of(s, off, ob);
            if (wr) begin
                case (wm)
                    WM_THROUGH:    arr_d[p] = word_of(s, off, nb);
                    WM_READ_FIRST: arr_d[p] = word_of(s, off, ob);
                    default:       arr_d[p] = arr_q[p];
                endcase
            end
            if (cfg_q[p][`EBR_CFG_PIPE_BIT]) begin
                if (edge_v & p_ce[p] & p_oce[p] & run)
                    dout_d[p] = arr_q[p];
            end else begin
                dout_d[p] = arr_d[p];
            end
            // Clear wins over any update on the same port edge
            if (edge_v & p_clr[p]) begin
                arr_d[p]  = 36'h0;
                dout_d[p] = 36'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mem_q  <= '{default: 9'h0};
            pclk_q <= 2'h0;
            arr_q  <= '{default: 36'h0};
            dout_q <= '{default: 36'h0};
        end else begin
            mem_q  <= mem_d;
            pclk_q <= pclk_d;
            arr_q  <= arr_d;
            dout_q <= dout_d;
        end
    end

    assign port_a_read_data = dout_q[0];
    assign port_b_read_data = dout_q[1];

endmodule // embedded_block_ram

// ===== tb/embedded_block_ram_assertions.sv
`timescale 1ns/1ns
module embedded_block_ram_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // Register read channel
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Port pins
    input wire logic        port_a_clk,
    input wire logic        port_a_clk_en,
    input wire logic        port_a_reg_clear,
    input wire logic [35:0] port_a_read_data,
    input wire logic        port_b_clk,
    input wire logic        port_b_clk_en,
    input wire logic        port_b_reg_clear,
    input wire logic [35:0] port_b_read_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready is not the inverse of rvalid");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read not answered in the next cycle");
    // A port edge is a low-to-high step seen at clk
    chk_a_quiet: assert property (
        !(port_a_clk && !$past(port_a_clk)) |=> $stable(port_a_read_data))
        else $error("port a output moved without a port edge");
    chk_b_quiet: assert property (
        !(port_b_clk && !$past(port_b_clk)) |=> $stable(port_b_read_data))
        else $error("port b output moved without a port edge");
    chk_a_frozen: assert property (
        port_a_clk && !$past(port_a_clk) && !port_a_clk_en
        && !port_a_reg_clear |=> $stable(port_a_read_data))
        else $error("port a output moved with clock enable low");
    chk_b_frozen: assert property (
        port_b_clk && !$past(port_b_clk) && !port_b_clk_en
        && !port_b_reg_clear |=> $stable(port_b_read_data))
        else $error("port b output moved with clock enable low");
    chk_a_clear: assert property (
        port_a_clk && !$past(port_a_clk) && port_a_reg_clear
        |=> port_a_read_data == 36'h0)
        else $error("port a clear did not zero the output");
endmodule // embedded_block_ram_checker

// ===== tb/fabric_port.sv
`timescale 1ns/1ns
module fabric_port (
    // Clock
    input wire logic    clk,
    // Port pins
    output logic        pclk,
    output logic        ce,
    output logic        clr,
    output logic        wsel,
    output logic        oe,
    output logic [13:0] addr,
    output logic [35:0] wdata,
    output logic [3:0]  ben
);
    initial begin
        pclk = 1'b0;
        ce = 1'b0;
        clr = 1'b0;
        wsel = 1'b0;
        oe = 1'b0;
        addr = 14'h0;
        wdata = 36'h0;
        ben = 4'h0;
    end

    task automatic access(input logic w, input logic [13:0] a,
                          input logic [35:0] d, input logic [3:0] be,
                          input logic c, input logic r, input logic o);
        @(posedge clk);
        wsel <= w;
        addr <= a;
        wdata <= d;
        ben <= be;
        ce <= c;
        clr <= r;
        oe <= o;
        pclk <= 1'b1;
        @(posedge clk);
        pclk <= 1'b0;
        // Stale address and data lines are scrambled so nothing relies on their held values
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule // fabric_port

// ===== tb/tb_embedded_block_ram.sv
`timescale 1ns/1ns
`include "embedded_block_ram_regs.svh"

module tb_embedded_block_ram
    import embedded_block_ram_pkg::*;
();
    localparam logic [1:0] rok  = `EBR_RESP_OKAY;
    localparam logic [1:0] rerr = `EBR_RESP_SLVERR;
    // Bus side
    logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  bsel;
    // Fabric side
    logic        a_clk, a_ce, a_clr, a_ws, a_oe;
    logic        b_clk, b_ce, b_clr, b_ws, b_oe;
    logic [13:0] a_ad, b_ad;
    logic [35:0] a_wd, b_wd, a_rd, b_rd;
    logic [3:0]  a_be, b_be;
    logic [8:0]  img [4] = '{9'h1a5, 9'h05a, 9'h133, 9'h0cc};
    int          mismatches = 0, comparisons = 0;

    embedded_block_ram DUT (
        .clk(clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .block_select(bsel),
        .port_a_clk(a_clk), .port_a_clk_en(a_ce),
        .port_a_reg_clear(a_clr), .port_a_write_sel(a_ws),
        .port_a_out_reg_en(a_oe), .port_a_addr(a_ad),
        .port_a_write_data(a_wd), .port_a_byte_en(a_be),
        .port_a_read_data(a_rd),
        .port_b_clk(b_clk), .port_b_clk_en(b_ce),
        .port_b_reg_clear(b_clr), .port_b_write_sel(b_ws),
        .port_b_out_reg_en(b_oe), .port_b_addr(b_ad),
        .port_b_write_data(b_wd), .port_b_byte_en(b_be),
        .port_b_read_data(b_rd)
    );
    fabric_port pa (.clk(clk), .pclk(a_clk), .ce(a_ce), .clr(a_clr),
        .wsel(a_ws), .oe(a_oe), .addr(a_ad), .wdata(a_wd), .ben(a_be));
    fabric_port pb (.clk(clk), .pclk(b_clk), .ce(b_ce), .clr(b_clr),
        .wsel(b_ws), .oe(b_oe), .addr(b_ad), .wdata(b_wd), .ben(b_be));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic cmp(input logic [35:0] g, input logic [35:0] x);
        comparisons++;
        if (g !== x) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp(bresp, e);
    endtask

    // A late rready exercises the slave holding its answer
    task automatic rchk(input logic [7:0] a, input logic [31:0] x,
                        input logic [1:0] e, input int sl);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (sl == 0);
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (n == sl) rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        cmp(rdata, x);
        cmp(rresp, e);
    endtask

    task automatic ctrl(input logic [2:0] m, input logic r);
        wr(`EBR_CTRL_OFS, {28'h0, r, m}, rok);
    endtask

    task automatic cfg(input logic p, input logic [3:0] sh,
                       input logic [1:0] wm, input logic pp,
                       input logic [2:0] bs);
        wr(p ? `EBR_PORT_B_CFG_OFS : `EBR_PORT_A_CFG_OFS,
           {22'h0, bs, pp, wm, sh}, rok);
    endtask

    task automatic t_regs();
        rchk(`EBR_STATUS_OFS, 32'h0, rok, 3);
        for (int m = 0; m < 5; m++) begin
            ctrl(m[2:0], 1'b0);
            rchk(`EBR_CTRL_OFS, 32'(m), rok, 0);
        end
        wr(8'h18, 32'h1, rerr);
        rchk(8'h18, 32'h0, rerr, 2);
    endtask

    task automatic t_rom();
        wr(`EBR_LOAD_ADDR_OFS, 32'h0, rok);
        foreach (img[i]) wr(`EBR_LOAD_DATA_OFS, {23'h0, img[i]}, rok);
        wr(`EBR_LOAD_ADDR_OFS, 32'h2, rok);
        rchk(`EBR_LOAD_DATA_OFS, 32'h133, rok, 0);
        ctrl(MODE_ROM, 1'b1);
        pa.access(1'b0, 14'h1, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h5a);
        pa.access(1'b1, 14'h1, 36'hff, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h5a);
        cfg(1'b0, SHAPE_X9, WM_NORMAL, 1'b0, 3'h0);
        cfg(1'b1, SHAPE_X18, WM_NORMAL, 1'b0, 3'h0);
        fork
            pa.access(1'b0, 14'h2, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
            pb.access(1'b0, 14'h1, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        join
        #1 cmp(a_rd, 36'h133);
        cmp(b_rd, 36'h19933);
    endtask

    task automatic t_wmode();
        logic [35:0] x;
        ctrl(MODE_SINGLE, 1'b1);
        for (int w = 0; w < 3; w++) begin
            cfg(1'b0, SHAPE_X8, w[1:0], 1'b0, 3'h0);
            pa.access(1'b1, 14'(w) + 14'h4, 36'h10 + w, 4'h0, 1, 0, 0);
            pa.access(1'b0, 14'h0, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
            #1 cmp(a_rd, 36'ha5);
            pa.access(1'b1, 14'(w) + 14'h4, 36'h30 + w, 4'h0, 1, 0, 0);
            x = (w == 0) ? 36'ha5 : (w == 1) ? 36'h31 : 36'h12;
            #1 cmp(a_rd, x);
            pa.access(1'b0, 14'(w) + 14'h4, 36'h0, 4'h0, 1, 0, 0);
            #1 cmp(a_rd, 36'h30 + w);
        end
    endtask

    task automatic t_bytes();
        cfg(1'b0, SHAPE_X16, WM_NORMAL, 1'b0, 3'h0);
        pa.access(1'b1, 14'h2, 36'hbeef, 4'h2, 1'b1, 1'b0, 1'b0);
        pa.access(1'b0, 14'h2, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'hbe30);
        cfg(1'b0, SHAPE_X4, WM_NORMAL, 1'b0, 3'h0);
        pa.access(1'b0, 14'h1, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'ha);
        cfg(1'b0, SHAPE_X36, WM_NORMAL, 1'b0, 3'h0);
        pa.access(1'b0, 14'h0, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h664ccb5a5);
    endtask

    task automatic t_gate();
        cfg(1'b0, SHAPE_X8, WM_THROUGH, 1'b0, 3'h3);
        bsel <= 3'h3;
        pa.access(1'b0, 14'h4, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h30);
        @(posedge clk) bsel <= 3'h0;
        pa.access(1'b1, 14'h8, 36'h77, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h30);
        @(posedge clk) bsel <= 3'h3;
        pa.access(1'b1, 14'h8, 36'h66, 4'h0, 1'b0, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h30);
        pa.access(1'b0, 14'h8, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h0);
        @(posedge clk) bsel <= 3'h0;
    endtask

    task automatic t_semi();
        ctrl(MODE_SEMI, 1'b1);
        cfg(1'b0, SHAPE_X8, WM_NORMAL, 1'b0, 3'h0);
        cfg(1'b1, SHAPE_X16, WM_NORMAL, 1'b0, 3'h0);
        pa.access(1'b1, 14'h8, 36'h12, 4'h0, 1'b1, 1'b0, 1'b0);
        pa.access(1'b1, 14'h9, 36'h34, 4'h0, 1'b1, 1'b0, 1'b0);
        pb.access(1'b1, 14'h4, 36'hffff, 4'h3, 1'b1, 1'b0, 1'b0);
        pb.access(1'b0, 14'h4, 36'h0, 4'h0, 1'b0, 1'b0, 1'b0);
        fork
            pa.access(1'b1, 14'ha, 36'h56, 4'h0, 1'b1, 1'b0, 1'b0);
            pb.access(1'b0, 14'h4, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        join
        #1 cmp(b_rd, 36'h3412);
        pb.access(1'b0, 14'h5, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(b_rd, 36'h56);
    endtask

    task automatic t_dual();
        ctrl(MODE_DUAL, 1'b1);
        cfg(1'b1, SHAPE_X8, WM_NORMAL, 1'b0, 3'h0);
        fork
            pa.access(1'b1, 14'hc, 36'h9a, 4'h0, 1'b1, 1'b0, 1'b0);
            pb.access(1'b1, 14'hd, 36'hbc, 4'h0, 1'b1, 1'b0, 1'b0);
        join
        fork
            pa.access(1'b0, 14'hd, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
            pb.access(1'b0, 14'hc, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        join
        #1 cmp(a_rd, 36'hbc);
        cmp(b_rd, 36'h9a);
        cfg(1'b0, SHAPE_X32, WM_NORMAL, 1'b0, 3'h0);
        pa.access(1'b1, 14'h3, 36'hffffffff, 4'hf, 1'b1, 1'b0, 1'b0);
        cfg(1'b0, SHAPE_X8, WM_NORMAL, 1'b0, 3'h0);
        pa.access(1'b0, 14'hc, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h9a);
    endtask

    task automatic t_pipe();
        ctrl(MODE_SINGLE, 1'b1);
        cfg(1'b0, SHAPE_X8, WM_NORMAL, 1'b1, 3'h0);
        pa.access(1'b0, 14'hd, 36'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        #1 cmp(a_rd, 36'h9a);
        pa.access(1'b0, 14'hc, 36'h0, 4'h0, 1'b1, 1'b0, 1'b1);
        #1 cmp(a_rd, 36'hbc);
        pa.access(1'b0, 14'hc, 36'h0, 4'h0, 1'b0, 1'b1, 1'b0);
        #1 cmp(a_rd, 36'h0);
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        bsel = 3'h0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_rom();
        t_wmode();
        t_bytes();
        t_gate();
        t_semi();
        t_dual();
        t_pipe();
        stop_test();
    end
endmodule // tb_embedded_block_ram

bind embedded_block_ram embedded_block_ram_checker u_chk (
    .clk(clk), .nrst(nrst),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .port_a_clk(port_a_clk), .port_a_clk_en(port_a_clk_en),
    .port_a_reg_clear(port_a_reg_clear),
    .port_a_read_data(port_a_read_data),
    .port_b_clk(port_b_clk), .port_b_clk_en(port_b_clk_en),
    .port_b_reg_clear(port_b_reg_clear),
    .port_b_read_data(port_b_read_data)
);
